// [hdl/du_top.sv]
// Summary of operation
// - Interrupt pin pulled low while any masked-in of eight conditions is active.
// - Interrupt status register shows all currently active conditions.
// - External transmit clock: data shifts out on its falling edge.
// - External receive clock: data sampled on its rising edge.
// - Host transfers happen only while chip select is low.
// - Data bit 0 is the least significant and first serial bit.
// - Write strobe low stores bus data into the selected register.
// - Read strobe low drives selected register onto the bus, else released.
// - Four select lines choose the register accessed.
// - Master reset initializes all outputs and registers.
// - Output 5 is general or channel B receive ready/full, open drain.
// - Outputs 6 and 7 are general or active-low transmit-empty, open drain.
// - Inputs 0 and 1 serve as active-low clear-to-send for A and B.
// - Input 2 may clock the counter/timer.
// - Transmitter frames bytes with start, optional parity and stop bits.
// - Receiver checks start, parity, stop; flags framing, overrun, break.
// - Each receiver and transmitter picks generator, timer or external clock.
// - All logic and baud generator run from the main clock.
// - Serial outputs stay at mark in reset, loopback or when disabled.
// - Reset is active high and disables transmit and receive.
module du_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host port
  input wire logic chipSelectN,
  input wire logic rdStrobeN,
  input wire logic wrStrobeN,
  input wire du_pkg::du_addr_t regSelect,
  input wire du_pkg::du_byte_t hostDataBusIn,
  output du_pkg::du_byte_t hostDataBusOut,
  output logic hostDataBusOe,
  // Serial lines
  input wire logic chanASerialIn,
  input wire logic chanBSerialIn,
  output logic chanASerialOut,
  output logic chanBSerialOut,
  // Multipurpose inputs
  input wire logic multiIn0,
  input wire logic multiIn1,
  input wire logic multiIn2,
  input wire logic multiIn3,
  input wire logic multiIn4,
  input wire logic multiIn5,
  input wire logic multiIn6,
  // Multipurpose outputs
  output logic multiOut5,
  output logic multiOut5Oe,
  output logic multiOut6,
  output logic multiOut6Oe,
  output logic multiOut7,
  output logic multiOut7Oe,
  // Interrupt, open drain
  output logic irqNOut,
  output logic irqNOe
);
  import du_pkg::*;
  typedef struct packed {
    logic [NUM_CHAN-1:0][7:0] mode;
    logic [NUM_CHAN-1:0][7:0] clkSel;
    logic [NUM_CHAN-1:0][3:0] txPre;
    du_byte_t imr;
    du_byte_t opcr;
    du_byte_t outPort;
    du_byte_t brgDiv;
    du_byte_t brgCnt;
    du_byte_t ctDiv;
    du_byte_t ctCnt;
    logic ctExt;
    logic ctFlag;
    logic ipcFlag;
    logic [NUM_IN-1:0] inPrev;
    logic wrAct;
    logic rdAct;
    du_addr_t wrAddr;
    du_addr_t rdAddr;
    du_byte_t wrData;
    du_byte_t busOut;
  } du_top_s;
  localparam du_top_s TOP_RST = '{mode: {NUM_CHAN{MODE_RST}}, clkSel: {NUM_CHAN{CLKSEL_RST}}, txPre: '0,
                                  imr: IMR_RST, opcr: OPCR_RST, outPort: OUT_RST, brgDiv: BRG_DIV_RST,
                                  brgCnt: BRG_DIV_RST, ctDiv: CT_DIV_RST, ctCnt: CT_DIV_RST, ctExt: 1'b0,
                                  ctFlag: 1'b0, ipcFlag: 1'b0, inPrev: '1, wrAct: 1'b0, rdAct: 1'b0,
                                  wrAddr: '0, rdAddr: '0, wrData: '0, busOut: '0};
  localparam logic [3:0] PRE_LAST = 4'(OVERSAMPLE - 1);
  du_top_s s;
  du_top_s next_s;

  logic [NUM_IN-1:0] multiIn;
  logic [NUM_CHAN-1:0] serIn;
  logic [NUM_CHAN-1:0] serOut;
  logic [NUM_CHAN-1:0] txSer;
  logic [NUM_CHAN-1:0] txEmpty;
  logic [NUM_CHAN-1:0] txTick16;
  logic [NUM_CHAN-1:0] txLoad;
  logic [NUM_CHAN-1:0] rxPop;
  logic [NUM_CHAN-1:0] rxReady;
  logic [NUM_CHAN-1:0] rxPe;
  logic [NUM_CHAN-1:0] rxFe;
  logic [NUM_CHAN-1:0] rxOv;
  logic [NUM_CHAN-1:0] rxBrk;
  du_byte_t [NUM_CHAN-1:0] rxData;
  du_byte_t isr;
  du_byte_t rdVal;
  logic wrNow;
  logic rdNow;
  logic brgTick;
  logic ctSrc;
  logic ctTick;
  logic [2:0] altCond;
  logic [2:0] mpOut;
  logic [2:0] mpOe;

  assign multiIn = {multiIn6, multiIn5, multiIn4, multiIn3, multiIn2, multiIn1, multiIn0};
  assign serIn = {chanBSerialIn, chanASerialIn};
  assign chanASerialOut = serOut[0];
  assign chanBSerialOut = serOut[1];

  // Host strobes qualified by chip select
  assign wrNow = !chipSelectN && !wrStrobeN;
  assign rdNow = !chipSelectN && !rdStrobeN;
  assign hostDataBusOe = rdNow;
  assign hostDataBusOut = s.busOut;

  // Baud generator and counter/timer, both in the main clock domain
  assign brgTick = (s.brgCnt == '0);
  assign ctSrc = s.ctExt ? (multiIn[CT_EXT_PIN] && !s.inPrev[CT_EXT_PIN]) : 1'b1;
  assign ctTick = ctSrc && (s.ctCnt == '0);

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    localparam int TX_PIN = EXT_TX_PIN_A + c * EXT_PIN_STRIDE;
    localparam int RX_PIN = EXT_RX_PIN_A + c * EXT_PIN_STRIDE;
    du_clk_e txSel;
    du_clk_e rxSel;
    logic txBitTick;
    logic rxTick;
    logic rxIn;
    logic ctsOk;
    logic loop;
    assign txSel = du_clk_e'(s.clkSel[c][CLK_TX_LSB +: 2]);
    assign rxSel = du_clk_e'(s.clkSel[c][CLK_RX_LSB +: 2]);
    assign txTick16[c] = (txSel == CLK_BRG) ? brgTick : ctTick;
    assign txBitTick = (txSel == CLK_EXT) ? (s.inPrev[TX_PIN] && !multiIn[TX_PIN])
                                          : (txTick16[c] && (s.txPre[c] == PRE_LAST));
    assign rxTick = (rxSel == CLK_EXT) ? (!s.inPrev[RX_PIN] && multiIn[RX_PIN])
                                       : ((rxSel == CLK_BRG) ? brgTick : ctTick);
    assign loop = s.mode[c][MODE_LOOP];
    assign rxIn = loop ? txSer[c] : serIn[c];
    assign serOut[c] = loop | txSer[c];
    assign ctsOk = !s.mode[c][MODE_CTS_EN] || !multiIn[CTS_PIN_A + c];
    assign isr[c * ISR_CHAN_STRIDE + ISR_TX_BIT] = txEmpty[c];
    assign isr[c * ISR_CHAN_STRIDE + ISR_RX_BIT] = rxReady[c];
    assign isr[c * ISR_CHAN_STRIDE + ISR_BRK_BIT] = rxBrk[c];

    du_tx u_tx (
      .clk(clk),
      .reset(reset),
      .bitTick(txBitTick),
      .enable(s.mode[c][MODE_TX_EN]),
      .parEn(s.mode[c][MODE_PAR_EN]),
      .parOdd(s.mode[c][MODE_PAR_ODD]),
      .twoStop(s.mode[c][MODE_TWO_STOP]),
      .ctsOk(ctsOk),
      .load(txLoad[c]),
      .loadData(s.wrData),
      .holdEmpty(txEmpty[c]),
      .serialOut(txSer[c])
    );

    du_rx u_rx (
      .clk(clk),
      .reset(reset),
      .sampleTick(rxTick),
      .x1Mode(rxSel == CLK_EXT),
      .enable(s.mode[c][MODE_RX_EN]),
      .parEn(s.mode[c][MODE_PAR_EN]),
      .parOdd(s.mode[c][MODE_PAR_ODD]),
      .serialIn(rxIn),
      .pop(rxPop[c]),
      .data(rxData[c]),
      .ready(rxReady[c]),
      .parErr(rxPe[c]),
      .frmErr(rxFe[c]),
      .overrun(rxOv[c]),
      .brk(rxBrk[c])
    );
  end

  assign isr[ISR_CT] = s.ctFlag;
  assign isr[ISR_IPC] = s.ipcFlag;
  assign irqNOut = 1'b0;
  assign irqNOe = |(isr & s.imr);

  // Outputs 5..7: general push-pull, or open-drain pull-down on their condition
  assign altCond = {txEmpty[1], txEmpty[0], rxReady[1]};
  for (genvar k = 0; k < 3; k++) begin : g_mpout
    assign mpOut[k] = s.opcr[OPCR_OUT5 + k] ? 1'b0 : s.outPort[OPCR_OUT5 + k];
    assign mpOe[k] = s.opcr[OPCR_OUT5 + k] ? altCond[k] : 1'b1;
  end
  assign multiOut5 = mpOut[0];
  assign multiOut5Oe = mpOe[0];
  assign multiOut6 = mpOut[1];
  assign multiOut6Oe = mpOe[1];
  assign multiOut7 = mpOut[2];
  assign multiOut7Oe = mpOe[2];

  always_comb begin
    next_s = s;
    txLoad = '0;
    rxPop = '0;
    rdVal = '0;
    next_s.wrAct = wrNow;
    next_s.rdAct = rdNow;
    if (wrNow) begin
      next_s.wrAddr = regSelect;
      next_s.wrData = hostDataBusIn;
    end
    if (rdNow) begin
      next_s.rdAddr = regSelect;
    end
    next_s.inPrev = multiIn;
    next_s.brgCnt = brgTick ? s.brgDiv : s.brgCnt - 8'h01;
    if (ctSrc) begin
      next_s.ctCnt = ctTick ? s.ctDiv : s.ctCnt - 8'h01;
    end
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (txTick16[c]) begin
        next_s.txPre[c] = s.txPre[c] + 4'h1;
      end
    end
    // Read data selection
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (regSelect == du_chan_reg(REG_MODE, c)) begin
        rdVal = s.mode[c];
      end else if (regSelect == du_chan_reg(REG_CLKSEL, c)) begin
        rdVal = s.clkSel[c];
      end else if (regSelect == du_chan_reg(REG_STAT, c)) begin
        rdVal[STAT_RX_RDY] = rxReady[c];
        rdVal[STAT_RX_FULL] = rxReady[c];
        rdVal[STAT_TX_EMPTY] = txEmpty[c];
        rdVal[STAT_PAR] = rxPe[c];
        rdVal[STAT_FRM] = rxFe[c];
        rdVal[STAT_OVR] = rxOv[c];
        rdVal[STAT_BRK] = rxBrk[c];
      end else if (regSelect == du_chan_reg(REG_DATA, c)) begin
        rdVal = rxData[c];
      end
    end
    if (regSelect == REG_IMR) begin
      rdVal = s.imr;
    end else if (regSelect == REG_ISR) begin
      rdVal = isr;
    end else if (regSelect == REG_OPCR) begin
      rdVal = s.opcr;
    end else if (regSelect == REG_OUT) begin
      rdVal = s.outPort;
    end else if (regSelect == REG_BRG) begin
      rdVal = s.brgDiv;
    end else if (regSelect == REG_INP) begin
      rdVal = {1'b0, ~multiIn};
    end else if (regSelect == REG_CTDIV) begin
      rdVal = s.ctDiv;
    end else if (regSelect == REG_CTCTL) begin
      rdVal[CTCTL_EXT] = s.ctExt;
    end
    next_s.busOut = rdVal;
    // Read side effects at end of the read strobe
    if (s.rdAct && !rdNow) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (s.rdAddr == du_chan_reg(REG_DATA, c)) begin
          rxPop[c] = 1'b1;
        end
      end
      if (s.rdAddr == REG_INP) begin
        next_s.ipcFlag = 1'b0;
      end
    end
    // Writes commit once, when the strobe rises
    if (s.wrAct && !wrNow) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (s.wrAddr == du_chan_reg(REG_MODE, c)) begin
          next_s.mode[c] = s.wrData;
        end else if (s.wrAddr == du_chan_reg(REG_CLKSEL, c)) begin
          next_s.clkSel[c] = s.wrData;
        end else if (s.wrAddr == du_chan_reg(REG_DATA, c)) begin
          txLoad[c] = 1'b1;
        end
      end
      if (s.wrAddr == REG_IMR) begin
        next_s.imr = s.wrData;
      end else if (s.wrAddr == REG_OPCR) begin
        next_s.opcr = s.wrData;
      end else if (s.wrAddr == REG_OUT) begin
        next_s.outPort = s.wrData;
      end else if (s.wrAddr == REG_BRG) begin
        next_s.brgDiv = s.wrData;
      end else if (s.wrAddr == REG_CTDIV) begin
        next_s.ctDiv = s.wrData;
      end else if (s.wrAddr == REG_CTCTL) begin
        next_s.ctExt = s.wrData[CTCTL_EXT];
        next_s.ctFlag = 1'b0;
      end
    end
    // Hardware sets win over clears
    if (ctTick) begin
      next_s.ctFlag = 1'b1;
    end
    if (|(multiIn[IPC_PINS-1:0] ^ s.inPrev[IPC_PINS-1:0])) begin
      next_s.ipcFlag = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= TOP_RST;
    end else begin
      s <= next_s;
    end
  end
endmodule : du_top

// [hdl/du_pkg.sv]
package du_pkg;
  localparam int NUM_CHAN = 2;
  localparam int DATA_BITS = 8;
  localparam int OVERSAMPLE = 16;
  localparam int SAMPLE_MID = 7;

  typedef logic [7:0] du_byte_t;
  typedef logic [3:0] du_addr_t;
  typedef enum logic [1:0] {CLK_BRG, CLK_CT, CLK_EXT} du_clk_e;

  // Register offsets; channel B registers add CHAN_B_BASE
  localparam du_addr_t REG_MODE = 4'h0;
  localparam du_addr_t REG_CLKSEL = 4'h1;
  localparam du_addr_t REG_STAT = 4'h2;
  localparam du_addr_t REG_DATA = 4'h3;
  localparam du_addr_t REG_IMR = 4'h4;
  localparam du_addr_t REG_ISR = 4'h5;
  localparam du_addr_t REG_OPCR = 4'h6;
  localparam du_addr_t REG_OUT = 4'h7;
  localparam du_addr_t REG_BRG = 4'hC;
  localparam du_addr_t REG_INP = 4'hD;
  localparam du_addr_t REG_CTDIV = 4'hE;
  localparam du_addr_t REG_CTCTL = 4'hF;
  localparam du_addr_t CHAN_B_BASE = 4'h8;

  // Mode register fields
  localparam int MODE_PAR_EN = 0;
  localparam int MODE_PAR_ODD = 1;
  localparam int MODE_TWO_STOP = 2;
  localparam int MODE_CTS_EN = 3;
  localparam int MODE_TX_EN = 4;
  localparam int MODE_RX_EN = 5;
  localparam int MODE_LOOP = 6;
  // Clock select fields
  localparam int CLK_TX_LSB = 0;
  localparam int CLK_RX_LSB = 2;
  // Status register fields
  localparam int STAT_RX_RDY = 0;
  localparam int STAT_RX_FULL = 1;
  localparam int STAT_TX_EMPTY = 2;
  localparam int STAT_PAR = 3;
  localparam int STAT_FRM = 4;
  localparam int STAT_OVR = 5;
  localparam int STAT_BRK = 6;
  // Interrupt status fields
  localparam int ISR_TX_BIT = 0;
  localparam int ISR_RX_BIT = 1;
  localparam int ISR_BRK_BIT = 2;
  localparam int ISR_CHAN_STRIDE = 4;
  localparam int ISR_CT = 3;
  localparam int ISR_IPC = 7;
  // Output configuration and counter control fields
  localparam int OPCR_OUT5 = 5;
  localparam int CTCTL_EXT = 0;
  // Multipurpose input pin roles
  localparam int CTS_PIN_A = 0;
  localparam int CT_EXT_PIN = 2;
  localparam int EXT_TX_PIN_A = 3;
  localparam int EXT_RX_PIN_A = 4;
  localparam int EXT_PIN_STRIDE = 2;
  localparam int IPC_PINS = 4;
  localparam int NUM_IN = 7;

  // Reset values
  localparam du_byte_t MODE_RST = 8'h00;
  localparam du_byte_t CLKSEL_RST = 8'h00;
  localparam du_byte_t IMR_RST = 8'h00;
  localparam du_byte_t OPCR_RST = 8'h00;
  localparam du_byte_t OUT_RST = 8'hFF;
  localparam du_byte_t BRG_DIV_RST = 8'h43;
  localparam du_byte_t CT_DIV_RST = 8'hFF;

  function automatic du_addr_t du_chan_reg(du_addr_t off, int c);
    return (c == 0) ? off : (off | CHAN_B_BASE);
  endfunction : du_chan_reg
endpackage : du_pkg

// [hdl/du_tx.sv]
module du_tx (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bit timing and format
  input wire logic bitTick,
  input wire logic enable,
  input wire logic parEn,
  input wire logic parOdd,
  input wire logic twoStop,
  input wire logic ctsOk,
  // Holding register
  input wire logic load,
  input wire du_pkg::du_byte_t loadData,
  output logic holdEmpty,
  // Serial line
  output logic serialOut
);
  import du_pkg::*;
  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_PAR, TX_STOP} du_tx_state_e;
  typedef struct packed {
    du_tx_state_e st;
    du_byte_t hold;
    logic holdFull;
    du_byte_t shift;
    logic [2:0] bitCnt;
    logic par;
    logic stop2;
    logic txd;
  } du_tx_s;
  localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);
  localparam du_tx_s TX_RST = '{st: TX_IDLE, hold: '0, holdFull: 1'b0, shift: '0, bitCnt: '0,
                                par: 1'b0, stop2: 1'b0, txd: 1'b1};
  du_tx_s s;
  du_tx_s next_s;

  always_comb begin
    next_s = s;
    if (bitTick) begin
      case (s.st)
        TX_IDLE: begin
          if (s.holdFull && enable && ctsOk) begin
            next_s.shift = s.hold;
            next_s.holdFull = 1'b0;
            next_s.txd = 1'b0;
            next_s.bitCnt = '0;
            next_s.par = parOdd;
            next_s.st = TX_DATA;
          end
        end
        TX_DATA: begin
          next_s.txd = s.shift[0];
          next_s.par = s.par ^ s.shift[0];
          next_s.shift = {1'b0, s.shift[7:1]};
          next_s.bitCnt = s.bitCnt + 3'h1;
          next_s.stop2 = twoStop;
          if (s.bitCnt == LAST_BIT) begin
            next_s.st = parEn ? TX_PAR : TX_STOP;
          end
        end
        TX_PAR: begin
          next_s.txd = s.par;
          next_s.st = TX_STOP;
        end
        TX_STOP: begin
          next_s.txd = 1'b1;
          next_s.stop2 = 1'b0;
          if (!s.stop2) begin
            next_s.st = TX_IDLE;
          end
        end
        default: next_s.st = TX_IDLE;
      endcase
    end
    // Disabled transmitter idles at mark
    if (!enable) begin
      next_s.st = TX_IDLE;
      next_s.txd = 1'b1;
    end
    if (load) begin
      next_s.hold = loadData;
      next_s.holdFull = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= TX_RST;
    end else begin
      s <= next_s;
    end
  end

  assign holdEmpty = !s.holdFull;
  assign serialOut = s.txd;
endmodule : du_tx

// [hdl/du_rx.sv]
module du_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sample timing and format
  input wire logic sampleTick,
  input wire logic x1Mode,
  input wire logic enable,
  input wire logic parEn,
  input wire logic parOdd,
  // Serial line
  input wire logic serialIn,
  // Received character
  input wire logic pop,
  output du_pkg::du_byte_t data,
  output logic ready,
  output logic parErr,
  output logic frmErr,
  output logic overrun,
  output logic brk
);
  import du_pkg::*;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT} du_rx_state_e;
  typedef struct packed {
    du_rx_state_e st;
    logic [3:0] sub;
    logic [2:0] bitCnt;
    du_byte_t shift;
    logic par;
    logic parBad;
    logic zeros;
    du_byte_t data;
    logic ready;
    logic pe;
    logic fe;
    logic ov;
    logic brk;
  } du_rx_s;
  localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);
  localparam logic [3:0] SUB_MID = 4'(SAMPLE_MID);
  localparam logic [3:0] SUB_LAST = 4'(OVERSAMPLE - 1);
  du_rx_s s;
  du_rx_s next_s;
  logic smp;

  // x1 samples every tick (rising edge of external clock), x16 at bit middle
  assign smp = x1Mode || (s.sub == SUB_LAST);

  always_comb begin
    next_s = s;
    if (pop) begin
      next_s.ready = 1'b0;
      next_s.ov = 1'b0;
    end
    if (sampleTick) begin
      next_s.sub = s.sub + 4'h1;
      case (s.st)
        RX_IDLE: begin
          if (!serialIn) begin
            next_s.st = x1Mode ? RX_DATA : RX_START;
            next_s.sub = '0;
            next_s.bitCnt = '0;
            next_s.par = parOdd;
            next_s.zeros = 1'b1;
          end
        end
        RX_START: begin
          if (s.sub == SUB_MID) begin
            next_s.sub = '0;
            next_s.st = serialIn ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (smp) begin
            next_s.shift = {serialIn, s.shift[7:1]};
            next_s.par = s.par ^ serialIn;
            next_s.zeros = s.zeros & !serialIn;
            next_s.bitCnt = s.bitCnt + 3'h1;
            if (s.bitCnt == LAST_BIT) begin
              next_s.st = parEn ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (smp) begin
            next_s.parBad = s.par ^ serialIn;
            next_s.zeros = s.zeros & !serialIn;
            next_s.st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (smp) begin
            next_s.ov = next_s.ready;
            next_s.data = s.shift;
            next_s.ready = 1'b1;
            next_s.pe = parEn && s.parBad;
            next_s.fe = !serialIn;
            next_s.brk = s.zeros && !serialIn;
            next_s.parBad = 1'b0;
            next_s.st = serialIn ? RX_IDLE : RX_WAIT;
          end
        end
        RX_WAIT: begin
          if (serialIn) begin
            next_s.st = RX_IDLE;
            next_s.brk = 1'b0;
          end
        end
        default: next_s.st = RX_IDLE;
      endcase
    end
    if (!enable) begin
      next_s.st = RX_IDLE;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign data = s.data;
  assign ready = s.ready;
  assign parErr = s.pe;
  assign frmErr = s.fe;
  assign overrun = s.ov;
  assign brk = s.brk;
endmodule : du_rx

// [test/du_top_sva.sv]
module du_top_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host port
  input wire logic chipSelectN,
  input wire logic rdStrobeN,
  input wire logic hostDataBusOe,
  // Pins
  input wire logic chanASerialOut,
  input wire logic chanBSerialOut,
  input wire logic multiOut5Oe,
  input wire logic multiOut6Oe,
  input wire logic multiOut7Oe,
  input wire logic irqNOut,
  input wire logic irqNOe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence released;
    $fell(reset);
  endsequence
  sequence lowA;
    !chanASerialOut [*8];
  endsequence
  sequence lowB;
    !chanBSerialOut [*8];
  endsequence
  a_read_drive: assert property (hostDataBusOe == (!chipSelectN && !rdStrobeN))
    else $error("bus drive does not follow select and read");
  a_cs_gate: assert property (chipSelectN |-> !hostDataBusOe)
    else $error("bus driven while deselected");
  a_oe_release: assert property ($rose(rdStrobeN) |-> !hostDataBusOe)
    else $error("bus held after read ends");
  a_irq_reset: assert property (released |-> !irqNOe && !irqNOut)
    else $error("interrupt active after reset");
  a_tx_mark: assert property (released |-> chanASerialOut && chanBSerialOut)
    else $error("serial output not at mark after reset");
  a_out_reset: assert property (released |-> multiOut5Oe && multiOut6Oe && multiOut7Oe)
    else $error("outputs not high after reset");
  a_start_a: assert property ($fell(chanASerialOut) |-> lowA)
    else $error("start bit too short on A");
  a_start_b: assert property ($fell(chanBSerialOut) |-> lowB)
    else $error("start bit too short on B");
endmodule : du_top_sva

bind du_top du_top_sva sva_u (.clk, .reset, .chipSelectN, .rdStrobeN, .hostDataBusOe, .chanASerialOut,
  .chanBSerialOut, .multiOut5Oe, .multiOut6Oe, .multiOut7Oe, .irqNOut, .irqNOe);

// [test/du_host.sv]
module du_host (
  // Clock
  input wire logic clk,
  // Bus to device
  output logic csN,
  output logic rdN,
  output logic wrN,
  output du_pkg::du_addr_t addr,
  output du_pkg::du_byte_t dout,
  input wire du_pkg::du_byte_t din
);
  timeunit 1ns;
  timeprecision 1ns;
  import du_pkg::*;
  initial begin
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    addr = 4'h0;
    dout = 8'h00;
  end
  // Only one strobe at a time, gap of a cycle after each
  task automatic wr(input du_addr_t a, input du_byte_t v, input logic off);
    @(negedge clk);
    csN = off;
    wrN = 1'b0;
    addr = a;
    dout = v;
    @(negedge clk);
    csN = 1'b1;
    wrN = 1'b1;
    dout = ~v;
    @(negedge clk);
  endtask : wr
  task automatic rd(input du_addr_t a, output du_byte_t v);
    @(negedge clk);
    csN = 1'b0;
    rdN = 1'b0;
    addr = a;
    repeat (2) @(negedge clk);
    v = din;
    csN = 1'b1;
    rdN = 1'b1;
    @(negedge clk);
  endtask : rd
endmodule : du_host

// [test/du_top_tb.sv]
module du_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import du_pkg::*;
  logic clk;
  logic reset;
  logic [6:0] ins;
  logic csN, rdN, wrN, oe, o5, o6, o7, e5, e6, e7, irqN, irqOe;
  logic [1:0] tx;
  du_addr_t addr;
  du_byte_t dout, din, got, d, md;
  du_byte_t regs [16];
  du_byte_t q [$];
  du_addr_t rl [7] = '{REG_MODE, REG_CLKSEL, REG_IMR, REG_OPCR, REG_OUT, REG_BRG, REG_CTDIV};
  du_addr_t wl [4] = '{REG_IMR, REG_OUT, REG_CTDIV, REG_BRG};
  du_byte_t im [4] = '{8'h01, 8'h10, 8'h00, 8'h02};
  du_byte_t pm [6] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h08, 8'h08};
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int k;
  logic extOn = 1'b0;
  du_host host_u (.clk(clk), .csN(csN), .rdN(rdN), .wrN(wrN), .addr(addr), .dout(dout), .din(din));
  du_top dut_u (.clk(clk), .reset(reset), .chipSelectN(csN), .rdStrobeN(rdN), .wrStrobeN(wrN),
    .regSelect(addr), .hostDataBusIn(dout), .hostDataBusOut(din), .hostDataBusOe(oe),
    .chanASerialIn(tx[1]), .chanBSerialIn(tx[0]), .chanASerialOut(tx[0]), .chanBSerialOut(tx[1]),
    .multiIn0(ins[0]), .multiIn1(ins[1]), .multiIn2(ins[2]), .multiIn3(ins[3]), .multiIn4(ins[4]),
    .multiIn5(ins[5]), .multiIn6(ins[6]), .multiOut5(o5), .multiOut5Oe(e5), .multiOut6(o6),
    .multiOut6Oe(e6), .multiOut7(o7), .multiOut7Oe(e7), .irqNOut(irqN), .irqNOe(irqOe));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      stop_test();
    end
  end
  // Free-running 1x clocks on inputs 3 and 6, 32 clocks a bit
  always @(negedge clk) begin
    if (extOn && cyc % 16 == 0) begin
      ins[3] <= ~ins[3];
      ins[6] <= ~ins[6];
    end
  end
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input du_byte_t g, input du_byte_t e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Write through the host and update the model
  task automatic wm(input du_addr_t a, input du_byte_t v);
    host_u.wr(a, v, 1'b0);
    if (a[1:0] == 2'h3 && !a[2]) q.push_back(v);
    else if (a inside {rl}) regs[a] = v;
  endtask : wm
  task automatic rc(input du_addr_t a);
    host_u.rd(a, got);
    chk(got, regs[a]);
  endtask : rc
  // Follow one character on a serial output, 32 clocks a bit
  task automatic watch(input int c, input du_byte_t v);
    du_byte_t s;
    int n;
    n = 0;
    while (tx[c] && n < 3000) begin
      @(negedge clk);
      n++;
    end
    repeat (16) @(negedge clk);
    chk({7'h0, tx[c]}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      repeat (32) @(negedge clk);
      s[i] = tx[c];
    end
    chk(s, v);
    if (md[MODE_PAR_EN]) begin
      repeat (32) @(negedge clk);
      chk({7'h0, tx[c]}, {7'h0, ^v ^ md[MODE_PAR_ODD]});
    end
    repeat (32) @(negedge clk);
    chk({7'h0, tx[c]}, 8'h01);
  endtask : watch
  initial begin
    reset = 1'b1;
    ins = 7'h7F;
    void'($urandom(30));
    regs = '{default: MODE_RST};
    regs[REG_OUT] = OUT_RST;
    regs[REG_BRG] = BRG_DIV_RST;
    regs[REG_CTDIV] = CT_DIV_RST;
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    foreach (rl[i]) rc(rl[i]);
    chk({1'b0, e5, e6, e7, o5, o6, o7, irqOe}, 8'h7E);
    chk({6'h0, tx}, 8'h03);
    host_u.wr(REG_ISR, 8'h00, 1'b0);
    host_u.rd(REG_ISR, got);
    chk(got & 8'h77, 8'h11);
    foreach (wl[i]) begin
      d = $urandom;
      wm(wl[i], d);
      host_u.wr(wl[i], ~d, 1'b1);
      rc(wl[i]);
    end
    chk({2'h0, e5, e6, e7, o5, o6, o7}, {5'h07, regs[REG_OUT][5], regs[REG_OUT][6], regs[REG_OUT][7]});
    foreach (im[i]) begin
      wm(REG_IMR, im[i]);
      chk({7'h0, irqOe}, {7'h0, |(im[i] & 8'h11)});
    end
    wm(REG_OPCR, 8'h40);
    chk({6'h0, e6, o6}, 8'h02);
    wm(REG_OPCR, 8'hE0);
    wm(REG_BRG, 8'h01);
    ins = 7'h7C;
    foreach (pm[m]) begin
      md = 8'h30 | pm[m];
      if (m == 5) begin
        wm(REG_CTDIV, 8'h01);
        wm(REG_CLKSEL, 8'h06);
        wm(REG_CLKSEL | CHAN_B_BASE, 8'h09);
        extOn = 1'b1;
      end
      wm(REG_MODE, md);
      wm(REG_MODE | CHAN_B_BASE, md);
      rc(REG_MODE);
      for (int c = 0; c < 2; c++) begin
        d = $urandom;
        fork
          watch(c, d);
          wm(REG_DATA | (c ? CHAN_B_BASE : 4'h0), d);
        join
        k = 0;
        do begin
          host_u.rd(REG_STAT | (c ? 4'h0 : CHAN_B_BASE), got);
          k++;
        end while (got[STAT_RX_RDY] !== 1'b1 && k < 50);
        chk(got & 8'h7F, 8'h07);
        chk({7'h0, e5}, {7'h0, c == 0});
        host_u.rd(REG_DATA | (c ? 4'h0 : CHAN_B_BASE), got);
        chk(got, q.pop_front());
        chk({7'h0, e5}, 8'h00);
      end
    end
    wm(REG_MODE, 8'h70);
    wm(REG_DATA, 8'h00);
    k = 0;
    repeat (400) @(negedge clk) k += !tx[0];
    chk({7'h0, k == 0}, 8'h01);
    stop_test();
  end
endmodule : du_top_tb
